/* sq_params.svh */
// Operation
// R1: Sixteen 16-bit transmit and receive word stores
// R2: Per-entry command byte sequences transfers autonomously
// R3: Command byte: protocol nibble plus select nibble
// R4: Protocol sets length, delays, deselect behaviour
// R5: Four select outputs, pattern per entry
// R6: Transfer length eight through sixteen bits
// R7: Hold or toggle selects, stop after queue
// R8: Divider from 8-bit field of control zero
// R9: Serial clock is system clock over twice divider
// R10: Divider field resets to four
// R11: Receive store fills while software drains it
// R12: Ascending entries, completion flag and interrupt
// R13: Receive word lands at transmitted entry index
`ifndef SQ_PARAMS_SVH
`define SQ_PARAMS_SVH

// Register byte addresses
`define SQ_CTRL0_ADDR     20'hFFC18
`define SQ_CTRL1_ADDR     20'hFFC1A
`define SQ_STATUS_ADDR    20'hFFC1C
`define SQ_MASK_ADDR      20'hFFC1E
`define SQ_RAM_BASE       20'hFFD00

// Queue store regions, selected by address bits 6:5
`define SQ_REGION_TX      2'h0
`define SQ_REGION_RX      2'h1
`define SQ_REGION_CMD     2'h2

// Control zero fields
`define SQ_DIV_LSB        0
`define SQ_DIV_MSB        7
`define SQ_BITS_LSB       12
`define SQ_BITS_MSB       15
`define SQ_CTRL0_RESET    16'h0004

// Control one fields
`define SQ_END_LSB        0
`define SQ_END_MSB        3
`define SQ_START_BIT      15

// Status and mask bits
`define SQ_ST_DONE        0
`define SQ_ST_RXWORD      1
`define SQ_ST_BUSY        2
`define SQ_EVENTS         2

// Select pattern while no peripheral is addressed
`define SQ_SELECT_IDLE    4'hF

// Timing
`define SQ_CLK_PERIOD_NS  4
`define SQ_LEAD_NS        40
`define SQ_TRAIL_NS       400
`define SQ_LEAD_CYCLES    ((`SQ_LEAD_NS + `SQ_CLK_PERIOD_NS - 1) / `SQ_CLK_PERIOD_NS)
`define SQ_TRAIL_CYCLES   ((`SQ_TRAIL_NS + `SQ_CLK_PERIOD_NS - 1) / `SQ_CLK_PERIOD_NS)

`endif

/* sq_pkg.sv */
package sq_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOAD  = 3'b001,
		ST_LEAD  = 3'b010,
		ST_SHIFT = 3'b011,
		ST_TRAIL = 3'b100,
		ST_STEP  = 3'b101
	} state_type;

	// Queue command byte layout
	typedef struct packed {
		logic       hold;     // Keep selects between entries
		logic       bits_en;  // Length from control zero, else 8
		logic       trail;    // Delay after the transfer
		logic       lead;     // Delay from select to first clock
		logic [3:0] select;   // Select pattern for this entry
	} cmd_type;

endpackage

/* serial_clock_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_clock_divider (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [7:0] divisor,
	output logic            tick
);

	logic [8:0] half;   // Half period in system clocks
	logic [8:0] count;  // Cycles into the half period

	// Zero means 256, values below 2 clamp to 2
	always_comb begin
		if (divisor == 8'h00) begin
			half = 9'h100; // R9
		end else if (divisor < 8'h02) begin
			half = 9'h002;
		end else begin
			half = {1'b0, divisor};
		end
	end

	// Half-period counter, restarts whenever idle
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			count <= 9'h000;
			tick  <= 1'b0;
		end else if (count == half - 9'h001) begin
			count <= 9'h000;
			tick  <= 1'b1; // R9
		end else begin
			count <= count + 9'h001;
			tick  <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* queued_serial_peripheral.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sq_params.svh"

module queued_serial_peripheral (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic [19:0] ADDR,
	input  wire logic [15:0] WR_DATA,
	input  wire logic        WR_EN,
	input  wire logic        RD_EN,
	output logic      [15:0] RD_DATA,
	output logic             IRQ,
	output logic             SCK,
	output logic             MOSI,
	input  wire logic        MISO,
	output logic      [3:0]  SELECT
);

	localparam logic [19:0] ram_base   = `SQ_RAM_BASE;
	localparam logic [7:0]  lead_len   = 8'(`SQ_LEAD_CYCLES);
	localparam logic [7:0]  trail_len  = 8'(`SQ_TRAIL_CYCLES);

	// Queue stores
	logic [15:0] tx_ram  [0:15];  // Words to send
	logic [15:0] rx_ram  [0:15];  // Words received
	logic [7:0]  cmd_ram [0:15];  // Command bytes

	// Software registers
	logic [15:0] ctrl0;           // Divider and length
	logic [3:0]  end_idx;         // Last entry of the queue
	logic [`SQ_EVENTS-1:0] status; // Sticky events
	logic [`SQ_EVENTS-1:0] mask;   // Interrupt enables

	// Sequencer
	sq_pkg::state_type state;     // Current state
	sq_pkg::cmd_type   cmd;       // Command of current entry
	logic [3:0]  idx;             // Current entry
	logic [15:0] tx_shift;        // Outgoing shifter
	logic [15:0] rx_shift;        // Incoming shifter
	logic [4:0]  bit_cnt;         // Bits still to send
	logic [7:0]  delay_cnt;       // Delay countdown
	logic        tick;            // Half-period strobe

	// Decode helpers
	logic        ram_hit;         // Address falls in the stores
	logic [1:0]  region;          // Which store
	logic [3:0]  ram_idx;         // Entry addressed
	logic        start;           // Software start request
	logic        rx_write;        // Engine stores a word
	logic        done_event;      // Queue finished
	logic [4:0]  len;             // Length of current entry
	logic [15:0] aligned;         // Transmit word, MSB first
	logic [`SQ_EVENTS-1:0] set_bits; // Events this cycle
	logic [`SQ_EVENTS-1:0] clr_bits; // Write-one clears

	// Address decode for the stores
	always_comb begin
		ram_hit = (ADDR[19:7] == ram_base[19:7]) && (ADDR[0] == 1'b0);
		region  = ADDR[6:5];
		ram_idx = ADDR[4:1];
	end

	// Start only from idle
	always_comb begin
		start = WR_EN && (ADDR == `SQ_CTRL1_ADDR) && WR_DATA[`SQ_START_BIT]
			&& (state == sq_pkg::ST_IDLE);
	end

	// Length from the protocol nibble
	always_comb begin
		len = 5'd8;
		if (cmd_ram[idx][6]) begin
			if (ctrl0[`SQ_BITS_MSB:`SQ_BITS_LSB] == 4'h0) begin
				len = 5'd16; // R6
			end else if (ctrl0[`SQ_BITS_MSB:`SQ_BITS_LSB] >= 4'h8) begin
				len = {1'b0, ctrl0[`SQ_BITS_MSB:`SQ_BITS_LSB]}; // R6
			end else begin
				len = 5'd8;
			end
		end
		aligned = tx_ram[idx] << (5'd16 - len);
	end

	// Control zero, divider resets to four
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ctrl0 <= `SQ_CTRL0_RESET; // R10
		end else if (WR_EN && ADDR == `SQ_CTRL0_ADDR) begin
			ctrl0 <= WR_DATA; // R8
		end
	end

	// Control one end index and mask
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			end_idx <= 4'h0;
			mask    <= '0;
		end else if (WR_EN && ADDR == `SQ_CTRL1_ADDR) begin
			end_idx <= WR_DATA[`SQ_END_MSB:`SQ_END_LSB];
		end else if (WR_EN && ADDR == `SQ_MASK_ADDR) begin
			mask <= WR_DATA[`SQ_EVENTS-1:0];
		end
	end

	// Software writes to transmit and command stores
	always_ff @(posedge CLK_SYS) begin
		if (WR_EN && ram_hit && region == `SQ_REGION_TX) begin
			tx_ram[ram_idx] <= WR_DATA; // R1
		end
		if (WR_EN && ram_hit && region == `SQ_REGION_CMD) begin
			cmd_ram[ram_idx] <= WR_DATA[7:0]; // R2
		end
	end

	// Engine fills receive store at the sent index
	always_ff @(posedge CLK_SYS) begin
		if (rx_write) begin
			rx_ram[idx] <= rx_shift; // R13
		end
	end

	// Event sources
	always_comb begin
		rx_write   = (state == sq_pkg::ST_SHIFT) && tick && SCK && (bit_cnt == 5'd1);
		done_event = (state == sq_pkg::ST_STEP) && (idx == end_idx);
		set_bits   = '0;
		set_bits[`SQ_ST_DONE]   = done_event; // R12
		set_bits[`SQ_ST_RXWORD] = rx_write;   // R11
		clr_bits   = '0;
		if (WR_EN && ADDR == `SQ_STATUS_ADDR) begin
			clr_bits = WR_DATA[`SQ_EVENTS-1:0];
		end
	end

	// Sticky status, set beats clear
	generate
		for (genvar i = 0; i < `SQ_EVENTS; i++) begin : g_status
			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					status[i] <= 1'b0;
				end else begin
					status[i] <= set_bits[i] | (status[i] & ~clr_bits[i]);
				end
			end
		end
	endgenerate

	// Level interrupt from unmasked events
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status & mask); // R12
		end
	end

	// Read data, valid only the cycle after the strobe
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !RD_EN) begin
			RD_DATA <= 16'h0000;
		end else if (ADDR == `SQ_CTRL0_ADDR) begin
			RD_DATA <= ctrl0;
		end else if (ADDR == `SQ_CTRL1_ADDR) begin
			RD_DATA <= {12'h000, end_idx};
		end else if (ADDR == `SQ_STATUS_ADDR) begin
			RD_DATA <= 16'({(state != sq_pkg::ST_IDLE), status});
		end else if (ADDR == `SQ_MASK_ADDR) begin
			RD_DATA <= 16'(mask);
		end else if (ram_hit && region == `SQ_REGION_TX) begin
			RD_DATA <= tx_ram[ram_idx];
		end else if (ram_hit && region == `SQ_REGION_RX) begin
			RD_DATA <= rx_ram[ram_idx]; // R11
		end else if (ram_hit && region == `SQ_REGION_CMD) begin
			RD_DATA <= {8'h00, cmd_ram[ram_idx]};
		end else begin
			RD_DATA <= 16'h0000;
		end
	end

	// Serial clock timebase
	serial_clock_divider u_divider (
		.clk     (CLK_SYS),
		.rst_n   (RST_N),
		.run     (state == sq_pkg::ST_SHIFT),
		.divisor (ctrl0[`SQ_DIV_MSB:`SQ_DIV_LSB]), // R8
		.tick    (tick)
	);

	// Queue sequencer
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state     <= sq_pkg::ST_IDLE;
			cmd       <= '0;
			idx       <= 4'h0;
			tx_shift  <= 16'h0000;
			rx_shift  <= 16'h0000;
			bit_cnt   <= 5'd0;
			delay_cnt <= 8'h00;
			SCK       <= 1'b0;
			SELECT    <= `SQ_SELECT_IDLE;
		end else begin
			case (state)
				sq_pkg::ST_IDLE: begin
					// Wait for software to start the queue
					if (start) begin
						idx   <= 4'h0; // R12
						state <= sq_pkg::ST_LOAD;
					end
				end
				sq_pkg::ST_LOAD: begin
					// Fetch entry, drive its select pattern
					cmd       <= sq_pkg::cmd_type'(cmd_ram[idx]); // R3
					SELECT    <= cmd_ram[idx][3:0]; // R5
					tx_shift  <= aligned;
					rx_shift  <= 16'h0000;
					bit_cnt   <= len; // R4
					delay_cnt <= lead_len;
					if (cmd_ram[idx][4]) begin
						state <= sq_pkg::ST_LEAD; // R4
					end else begin
						state <= sq_pkg::ST_SHIFT;
					end
				end
				sq_pkg::ST_LEAD: begin
					// Select-to-first-clock delay
					if (delay_cnt == 8'h01) begin
						state <= sq_pkg::ST_SHIFT;
					end else begin
						delay_cnt <= delay_cnt - 8'h01;
					end
				end
				sq_pkg::ST_SHIFT: begin
					// Rise samples, fall advances
					if (tick && !SCK) begin
						SCK      <= 1'b1;
						rx_shift <= {rx_shift[14:0], MISO};
					end else if (tick) begin
						SCK <= 1'b0;
						if (bit_cnt == 5'd1) begin
							delay_cnt <= trail_len;
							if (cmd.trail) begin
								state <= sq_pkg::ST_TRAIL; // R4
							end else begin
								state <= sq_pkg::ST_STEP;
							end
						end else begin
							bit_cnt  <= bit_cnt - 5'd1;
							tx_shift <= {tx_shift[14:0], 1'b0};
						end
					end
				end
				sq_pkg::ST_TRAIL: begin
					// Delay after the transfer
					if (delay_cnt == 8'h01) begin
						state <= sq_pkg::ST_STEP;
					end else begin
						delay_cnt <= delay_cnt - 8'h01;
					end
				end
				sq_pkg::ST_STEP: begin
					// Advance or finish the queue
					if (idx == end_idx) begin
						SELECT <= `SQ_SELECT_IDLE; // R7
						state  <= sq_pkg::ST_IDLE; // R12
					end else begin
						idx   <= idx + 4'h1; // R12
						state <= sq_pkg::ST_LOAD; // R2
						if (!cmd.hold) begin
							SELECT <= `SQ_SELECT_IDLE; // R7
						end
					end
				end
				default: begin
					state <= sq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Data out straight from the shifter
	always_comb begin
		MOSI = tx_shift[15];
	end

endmodule

`default_nettype wire

/* sq_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module sq_checker (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic [19:0] ADDR,
	input  wire logic [15:0] WR_DATA,
	input  wire logic        WR_EN,
	input  wire logic        RD_EN,
	input  wire logic [15:0] RD_DATA,
	input  wire logic        IRQ,
	input  wire logic        SCK,
	input  wire logic        MOSI,
	input  wire logic [3:0]  SELECT
);
	logic [15:0] c0; // Control zero shadow
	logic [1:0]  mk; // Mask shadow
	logic [8:0]  hc; // Serial clock high run
	logic [8:0]  ev; // Divider in effect
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// Shadow the written registers
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			c0 <= 16'h0004;
			mk <= 2'h0;
		end else if (WR_EN && ADDR == 20'hFFC18) begin
			c0 <= WR_DATA;
		end else if (WR_EN && ADDR == 20'hFFC1E) begin
			mk <= WR_DATA[1:0];
		end
	end
	// Count cycles of serial clock high
	always_ff @(posedge CLK_SYS) begin
		hc <= SCK ? hc + 9'h001 : 9'h000;
	end
	// Zero means 256, one acts as two
	assign ev = (c0[7:0] == 8'h00) ? 9'h100 :
		(c0[7:0] == 8'h01) ? 9'h002 : {1'b0, c0[7:0]};
	property p_sck_idle;
		SELECT == 4'hF |-> !SCK;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("clock while deselected");
	property p_sck_high;
		$fell(SCK) |-> hc == ev;
	endproperty
	a_sck_high: assert property (p_sck_high) else $error("clock high length");
	property p_mosi_hold;
		SCK && $past(SCK) |-> $stable(MOSI);
	endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("data moved");
	property p_sel_hold;
		SCK |-> $stable(SELECT);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select moved");
	property p_first_clk;
		$past(SELECT) == 4'hF && SELECT != 4'hF |-> !SCK [*2];
	endproperty
	a_first_clk: assert property (p_first_clk) else $error("clock too early");
	property p_rd_idle;
		!$past(RD_EN) |-> RD_DATA == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_ctrl0;
		$past(RD_EN) && $past(ADDR) == 20'hFFC18 |-> RD_DATA == $past(c0);
	endproperty
	a_ctrl0: assert property (p_ctrl0) else $error("control zero value");
	property p_irq_mask;
		IRQ |-> mk != 2'h0 || $past(mk) != 2'h0;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule

bind queued_serial_peripheral sq_checker sq_checker_i (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
	.WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .IRQ(IRQ),
	.SCK(SCK), .MOSI(MOSI), .SELECT(SELECT)
);
`default_nettype wire

/* spi_peripheral_model.sv */
`timescale 1ns/1ps
`default_nettype none

module spi_peripheral_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic [3:0]  sel,
	output logic             miso,
	output logic      [15:0] got
);
	logic sck_q; // Last serial clock
	// Echo inverted data, wiggle when not selected
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			miso <= 1'b0;
		end else begin
			miso <= (sel == 4'hF) ? ~miso : ~mosi;
		end
	end
	// Capture data out on serial clock rise
	always_ff @(posedge clk) begin
		sck_q <= sck;
		if (sck && !sck_q) begin
			got <= {got[14:0], mosi};
		end
	end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        clk = 0;   // System clock
	logic        rst_n = 0; // Reset, low active
	logic        wr = 0;    // Write strobe
	logic        rd = 0;    // Read strobe
	logic [19:0] addr = 0;  // Bus address
	logic [15:0] wd = 0;    // Write data
	logic [15:0] rdat;      // Read data
	logic [15:0] q;         // Last read
	logic [15:0] got;       // Words seen by peripheral
	logic [15:0] tx[16];    // Queued words
	logic [7:0]  cm[16];    // Queued commands
	logic [3:0]  sel;       // Selects
	logic        irq;       // Interrupt
	logic        sck;       // Serial clock
	logic        mosi;      // Data out
	logic        miso;      // Data in
	int          bad_count = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          n, lf, dv, mk, ln;
	always #2 clk = ~clk;
	queued_serial_peripheral queued_serial_peripheral_i (.CLK_SYS(clk), .RST_N(rst_n),
		.ADDR(addr), .WR_DATA(wd), .WR_EN(wr), .RD_EN(rd), .RD_DATA(rdat), .IRQ(irq),
		.SCK(sck), .MOSI(mosi), .MISO(miso), .SELECT(sel));
	spi_peripheral_model spi_peripheral_model_i (.clk(clk), .rst_n(rst_n), .sck(sck),
		.mosi(mosi), .sel(sel), .miso(miso), .got(got));
	// Compare one value
	task automatic cmp(string s, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	// One bus write
	task automatic wrr(logic [19:0] a, logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	// One bus read, data a cycle later
	task automatic rdr(logic [19:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 q = rdat;
	endtask
	// Mask of the low l bits of inverted t
	function automatic logic [15:0] xr(logic [15:0] t, int l);
		return ~t & 16'((17'h1 << l) - 1);
	endfunction
	// Bits sent by a command
	function automatic int blen(logic [7:0] c);
		if (!c[6] || (lf > 0 && lf < 8)) return 8;
		return (lf == 0) ? 16 : lf;
	endfunction
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			finish_test;
		end
	end
	initial begin
		void'($urandom(32'h43C5));
		repeat (5) @(posedge clk);
		rst_n <= 1;
		rdr(20'hFFC18); cmp("ctrl0", 16'h0004, q);
		rdr(20'hFFC1C); cmp("status", 16'h0000, q);
		rdr(20'hFFC30); cmp("unmapped", 16'h0000, q);
		cmp("select", 16'h000F, {12'h0, sel});
		$display("test reset end");
		// Queues: long length, short field, random, full queue
		for (int k = 0; k < 4; k++) begin
			n = (k == 3) ? 16 : 1 + $urandom % 4;
			lf = (k == 0) ? 0 : (k == 1) ? 5 : $urandom % 16;
			dv = 2 + $urandom % 4;
			mk = (k == 1) ? 0 : 3;
			wrr(20'hFFC18, {lf[3:0], 4'h0, dv[7:0]});
			rdr(20'hFFC18); cmp("ctrl0", {lf[3:0], 4'h0, dv[7:0]}, q);
			wrr(20'hFFC1E, 16'(mk));
			for (int i = 0; i < n; i++) begin
				tx[i] = 16'($urandom);
				cm[i] = 8'($urandom);
				cm[i][3:0] = 4'($urandom % 15);
				wrr(20'hFFD00 + 20'(2 * i), tx[i]);
				wrr(20'hFFD40 + 20'(2 * i), {8'h00, cm[i]});
			end
			wrr(20'hFFC1A, 16'h8000 | 16'(n - 1));
			q = 0;
			for (int w = 0; w < 5000 && !q[0]; w++) rdr(20'hFFC1C);
			cmp("status", 16'h0003, q & 16'h0007);
			cmp("irq", 16'(mk != 0), {15'h0, irq});
			for (int i = 0; i < n; i++) begin
				rdr(20'hFFD20 + 20'(2 * i));
				cmp("rx", xr(tx[i], blen(cm[i])), q);
			end
			ln = blen(cm[n - 1]);
			cmp("sent", ~xr(tx[n - 1], ln) & xr(0, ln), got & xr(0, ln));
			wrr(20'hFFC1C, 16'h0003);
			rdr(20'hFFC1C); cmp("cleared", 16'h0000, q);
			cmp("irq off", 16'h0000, {15'h0, irq});
			$display("test queue %0d end", k);
		end
		finish_test;
	end
endmodule
`default_nettype wire
